// ---- hdl/pwr_mode_regs.svh ----
// constants of the core power-mode controller: bit positions, reset values
// and timing counts; assumes a 100 MHz reference clock on REF_CLK
//
// Contract
// - only two low-power states: idle and stop
// - idle halts core, clocks and peripherals run
// - stop halts core, irqs, internal oscillator
// - oscillators off: only reset resumes operation
// - suspended oscillator wakes on usb or vbus
// - idle bit set enters idle after instruction
// - idle keeps registers and memory unchanged
// - idle ends on enabled interrupt or reset
// - interrupt wake clears idle bit, core resumes
// - service interrupt, then resume after idle write
// - reset from idle: reset sequence, vector zero
// - enabled watchdog reset ends idle
// - stop bit set enters stop after instruction
// - stop halts oscillator, core, digital peripherals
// - stop ends only by reset, vector zero
// - missing clock detector reset ends stop
`ifndef PWR_MODE_REGS_SVH
`define PWR_MODE_REGS_SVH

// power control register layout
`define PWRCTL_IDLE_BIT  0
`define PWRCTL_STOP_BIT  1
`define PWRCTL_GF_LSB    2
`define PWRCTL_GF_MSB    7
`define PWRCTL_RESET     8'h00
`define PWRCTL_GF_RESET  6'h00

// reset sequence
`define RESET_VECTOR     16'h0000
`define RST_SEQ_CYCLES   3'h4

// pin synchroniser reset image: ext reset pin idles high
`define PIN_SYNC_RESET   3'h1

// missing clock detector timeout
`define CLK_PERIOD_NS    10
`define CKDET_TIMEOUT_US   100
`define CKDET_TIMEOUT_CYC  ((`CKDET_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

// mode codes shown on the mode output
`define MODE_RUN         2'h0
`define MODE_IDLE        2'h1
`define MODE_STOP        2'h2
`define MODE_RESET       2'h3

`endif

// ---- hdl/pwr_mode_pkg.sv ----
// types of the core power-mode controller
// assumes the constants header is compiled alongside
package pwr_mode_pkg;

   // controller states
   typedef enum logic [2:0] {
      ST_RUN,
      ST_IDLE_PEND,
      ST_IDLE,
      ST_STOP_PEND,
      ST_STOP,
      ST_RESET
   } pwr_state_t;

   // asynchronous pin inputs, bit 2 first
   typedef struct packed {
      logic vbus;
      logic usb_nonidle;
      logic ext_reset_n;
   } pin_in_t;

   // registered controls toward the core and clock tree
   typedef struct packed {
      logic        cpu_halt;
      logic        cpu_clk_en;
      logic        periph_clk_en;
      logic        irq_active;
      logic        int_osc_en;
      logic        reset_out;
      logic        irq_wake;
      logic [1:0]  mode;
      logic [15:0] reset_vector;
      logic [7:0]  ctl_rdata;
   } ctl_out_t;

endpackage : pwr_mode_pkg

// ---- hdl/pin_sync.sv ----
// three-stage synchroniser with agreement filter for the pin inputs
// assumes pins are fully asynchronous to REF_CLK
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"

module pin_sync
   import pwr_mode_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire pin_in_t pin_in,
   output pin_in_t      pin_out
);

   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] stable_reg;
   logic [2:0] stable_next;

   // take a level only once stages two and three agree
   always_comb
   begin
      stable_next = (~(s2_reg ^ s3_reg) & s3_reg)
                  | ((s2_reg ^ s3_reg) & stable_reg);
   end

   // first stage is read by the second only
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_reg     <= `PIN_SYNC_RESET;
         s2_reg     <= `PIN_SYNC_RESET;
         s3_reg     <= `PIN_SYNC_RESET;
         stable_reg <= `PIN_SYNC_RESET;
      end
      else
      begin
         s1_reg     <= pin_in;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         stable_reg <= stable_next;
      end
   end

   assign pin_out = stable_reg;

endmodule : pin_sync

// ---- hdl/cpu_power_mode_control.sv ----
// idle and stop mode controller of the processor core, with reset
// exit and internal oscillator suspend wake
// assumes core, interrupt logic and watchdog share REF_CLK; reset pin,
// usb activity and vbus are asynchronous pins
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"

module cpu_power_mode_control
   import pwr_mode_pkg::*;
#(
   parameter int CKDET_TIMEOUT_CYC = `CKDET_TIMEOUT_CYC
)
(
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        PWRCTL_WR,
   input  wire logic [7:0]  PWRCTL_WDATA,
   input  wire logic        INSTR_DONE,
   input  wire logic        IRQ_PENDING,
   input  wire logic        INT_RESET_REQ,
   input  wire logic        WDOG_ENABLE,
   input  wire logic        WDOG_EXPIRED,
   input  wire logic        CKDET_ENABLE,
   input  wire logic        EXT_RESET_N,
   input  wire logic        SUSPEND_REQ,
   input  wire logic        USB_NONIDLE,
   input  wire logic        VBUS,
   input  wire logic        VBUS_WAKE_POLARITY,
   output logic             CPU_HALT,
   output logic             CPU_CLK_EN,
   output logic             PERIPH_CLK_EN,
   output logic             IRQ_ACTIVE,
   output logic             INT_OSC_EN,
   output logic             RESET_OUT,
   output logic             IRQ_WAKE,
   output logic [1:0]       POWER_MODE,
   output logic [15:0]      RESET_VECTOR,
   output logic [7:0]       PWRCTL_RDATA
);

   pin_in_t    pins_raw;
   pin_in_t    pins_s;
   pwr_state_t state_reg;
   pwr_state_t state_next;
   logic [5:0] gflags_reg;
   logic [5:0] gflags_next;
   logic       idle_sel_reg;
   logic       idle_sel_next;
   logic       stop_sel_reg;
   logic       stop_sel_next;
   logic [13:0] ckdet_cnt_reg;
   logic [13:0] ckdet_cnt_next;
   logic [2:0] rst_cnt_reg;
   logic [2:0] rst_cnt_next;
   logic       osc_susp_reg;
   logic       osc_susp_next;
   ctl_out_t   out_reg;
   ctl_out_t   out_next;
   logic       reset_cause;
   logic       ckdet_expire;
   logic       wr_idle;
   logic       wr_stop;
   logic       osc_wake;

   // states in which the core executes nothing
   function automatic logic core_halted(input pwr_state_t s);
      core_halted = (s == ST_IDLE) || (s == ST_STOP) || (s == ST_RESET);
   endfunction : core_halted

   // mode code shown to software and the clock tree
   function automatic logic [1:0] mode_code(input pwr_state_t s);
      unique case (s)
         ST_IDLE:  mode_code = `MODE_IDLE;
         ST_STOP:  mode_code = `MODE_STOP;
         ST_RESET: mode_code = `MODE_RESET;
         default:  mode_code = `MODE_RUN;
      endcase
   endfunction : mode_code

   // pins cross into REF_CLK through the filter
   assign pins_raw.vbus        = VBUS;
   assign pins_raw.usb_nonidle = USB_NONIDLE;
   assign pins_raw.ext_reset_n = EXT_RESET_N;

   pin_sync u_pin_sync
   (
      .clk     (REF_CLK),
      .rst     (RST),
      .pin_in  (pins_raw),
      .pin_out (pins_s)
   );

   // reset sources; detector fires after a full timeout in stop
   assign ckdet_expire = (state_reg == ST_STOP) && CKDET_ENABLE
                      && (ckdet_cnt_reg == 14'(CKDET_TIMEOUT_CYC - 1));
   assign reset_cause  = !pins_s.ext_reset_n || INT_RESET_REQ
                      || (WDOG_ENABLE && WDOG_EXPIRED)
                      || ckdet_expire;
   // both bits in one write count as stop
   assign wr_stop = PWRCTL_WR && PWRCTL_WDATA[`PWRCTL_STOP_BIT];
   assign wr_idle = PWRCTL_WR && PWRCTL_WDATA[`PWRCTL_IDLE_BIT]
                 && !wr_stop;
   assign osc_wake = pins_s.usb_nonidle
                  || (pins_s.vbus == VBUS_WAKE_POLARITY);

   // mode sequencing; reset outranks every other event
   always_comb
   begin
      state_next    = state_reg;
      gflags_next   = gflags_reg;
      idle_sel_next = idle_sel_reg;
      stop_sel_next = stop_sel_reg;
      rst_cnt_next  = rst_cnt_reg;
      if (PWRCTL_WR)
         gflags_next = PWRCTL_WDATA[`PWRCTL_GF_MSB:`PWRCTL_GF_LSB];
      if (reset_cause)
      begin
         state_next    = ST_RESET;
         rst_cnt_next  = `RST_SEQ_CYCLES;
         gflags_next   = `PWRCTL_GF_RESET;
         idle_sel_next = 1'b0;
         stop_sel_next = 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_RUN:
            begin
               if (wr_stop)
               begin
                  stop_sel_next = 1'b1;
                  state_next = INSTR_DONE ? ST_STOP : ST_STOP_PEND;
               end
               else if (wr_idle)
               begin
                  idle_sel_next = 1'b1;
                  state_next = INSTR_DONE ? ST_IDLE : ST_IDLE_PEND;
               end
            end
            ST_IDLE_PEND:
            begin
               if (wr_stop)
               begin
                  stop_sel_next = 1'b1;
                  idle_sel_next = 1'b0;
                  state_next = INSTR_DONE ? ST_STOP : ST_STOP_PEND;
               end
               else if (INSTR_DONE)
                  state_next = ST_IDLE;
            end
            ST_STOP_PEND:
            begin
               if (INSTR_DONE)
                  state_next = ST_STOP;
            end
            ST_IDLE:
            begin
               // only an enabled interrupt wakes; flags stay put
               if (IRQ_PENDING)
               begin
                  state_next    = ST_RUN;
                  idle_sel_next = 1'b0;
               end
            end
            ST_STOP:
            begin
               state_next = ST_STOP;
            end
            ST_RESET:
            begin
               if (rst_cnt_reg == 3'h1)
                  state_next = ST_RUN;
               else
                  rst_cnt_next = 3'(rst_cnt_reg - 3'h1);
            end
         endcase
      end
   end

   // detector counts only while stopped with the detector on
   always_comb
   begin
      ckdet_cnt_next = 14'h0000;
      if ((state_reg == ST_STOP) && CKDET_ENABLE && !ckdet_expire)
         ckdet_cnt_next = 14'(ckdet_cnt_reg + 14'h0001);
   end

   // oscillator suspend; a wake that meets a request wins, no lost wake
   always_comb
   begin
      osc_susp_next = osc_susp_reg;
      if (SUSPEND_REQ)
         osc_susp_next = 1'b1;
      if (osc_wake || reset_cause)
         osc_susp_next = 1'b0;
   end

   // output image derived from the next state so ports come from flops
   always_comb
   begin
      out_next               = '0;
      out_next.cpu_halt      = core_halted(state_next);
      out_next.cpu_clk_en    = !core_halted(state_next);
      out_next.periph_clk_en = (state_next != ST_STOP);
      out_next.irq_active    = (state_next != ST_STOP);
      out_next.int_osc_en    = (state_next != ST_STOP)
                            && !osc_susp_next;
      out_next.reset_out     = (state_next == ST_RESET);
      out_next.irq_wake      = (state_reg == ST_IDLE)
                            && (state_next == ST_RUN);
      out_next.mode          = mode_code(state_next);
      out_next.reset_vector  = `RESET_VECTOR;
      // mode select bits always read back as zero
      out_next.ctl_rdata     = {gflags_next, 2'h0};
   end

   // all state registers
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         state_reg    <= ST_RUN;
         gflags_reg   <= `PWRCTL_GF_RESET;
         idle_sel_reg <= 1'b0;
         stop_sel_reg <= 1'b0;
         ckdet_cnt_reg <= 14'h0000;
         rst_cnt_reg  <= 3'h0;
         osc_susp_reg <= 1'b0;
         out_reg      <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         gflags_reg   <= gflags_next;
         idle_sel_reg <= idle_sel_next;
         stop_sel_reg <= stop_sel_next;
         ckdet_cnt_reg <= ckdet_cnt_next;
         rst_cnt_reg  <= rst_cnt_next;
         osc_susp_reg <= osc_susp_next;
         out_reg      <= out_next;
      end
   end

   // ports straight from the output register
   assign CPU_HALT      = out_reg.cpu_halt;
   assign CPU_CLK_EN    = out_reg.cpu_clk_en;
   assign PERIPH_CLK_EN = out_reg.periph_clk_en;
   assign IRQ_ACTIVE    = out_reg.irq_active;
   assign INT_OSC_EN    = out_reg.int_osc_en;
   assign RESET_OUT     = out_reg.reset_out;
   assign IRQ_WAKE      = out_reg.irq_wake;
   assign POWER_MODE    = out_reg.mode;
   assign RESET_VECTOR  = out_reg.reset_vector;
   assign PWRCTL_RDATA  = out_reg.ctl_rdata;

   // checks on the registered behaviour
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   idle_entry_a: assert property (
      (state_reg == ST_IDLE_PEND) && INSTR_DONE && !wr_stop && !reset_cause
      |=> (state_reg == ST_IDLE) && CPU_HALT && (POWER_MODE == `MODE_IDLE))
      else $error("idle not entered after the instruction");

   idle_clocks_a: assert property (
      (state_reg == ST_IDLE) |-> PERIPH_CLK_EN && IRQ_ACTIVE && !CPU_CLK_EN)
      else $error("idle must keep peripheral clocks");

   stop_gating_a: assert property (
      (state_reg == ST_STOP)
      |-> CPU_HALT && !IRQ_ACTIVE && !INT_OSC_EN && !PERIPH_CLK_EN)
      else $error("stop gating incomplete");

   irq_wake_a: assert property (
      (state_reg == ST_IDLE) && IRQ_PENDING && !reset_cause
      |=> IRQ_WAKE && !idle_sel_reg && CPU_CLK_EN ##1 !IRQ_WAKE)
      else $error("interrupt wake from idle wrong");

   stop_hold_a: assert property (
      (state_reg == ST_STOP) && !reset_cause |=> (state_reg == ST_STOP))
      else $error("stop left without reset");

   // high for the four cycles after the last cause edge, low the cycle after
   reset_seq_a: assert property (
      reset_cause ##1 !reset_cause [*4]
      |-> (RESET_OUT && $past(RESET_OUT, 3))
      ##1 (!RESET_OUT && (RESET_VECTOR == `RESET_VECTOR)))
      else $error("reset sequence length or vector wrong");

   wdog_reset_a: assert property (
      WDOG_ENABLE && WDOG_EXPIRED |=> RESET_OUT && (state_reg == ST_RESET))
      else $error("watchdog reset not taken");

   ckdet_count_a: assert property (
      (state_reg == ST_STOP) && CKDET_ENABLE && !ckdet_expire
      |=> (ckdet_cnt_reg == 14'($past(ckdet_cnt_reg) + 14'h0001))
      && (ckdet_cnt_reg < 14'(CKDET_TIMEOUT_CYC)))
      else $error("detector counter did not advance");

   ckdet_fire_a: assert property (
      ckdet_expire |=> RESET_OUT && (ckdet_cnt_reg == 14'h0000))
      else $error("detector timeout did not reset");

   both_bits_a: assert property (
      (state_reg == ST_RUN) && PWRCTL_WR
      && (PWRCTL_WDATA[1:0] == 2'h3) && !reset_cause
      |=> stop_sel_reg && !idle_sel_reg
      && (state_reg inside {ST_STOP_PEND, ST_STOP}))
      else $error("double select not taken as stop");

   stop_sel_a: assert property (
      (state_reg == ST_STOP) |-> stop_sel_reg)
      else $error("stop entered without its select");

   osc_wake_a: assert property (
      osc_susp_reg && !osc_wake && !reset_cause |=> osc_susp_reg
      ##0 (!INT_OSC_EN))
      else $error("oscillator left suspend without wake");

   gflag_keep_a: assert property (
      (state_reg == ST_IDLE) && !PWRCTL_WR && !reset_cause
      |=> $stable(gflags_reg) && $stable(PWRCTL_RDATA))
      else $error("flags changed during idle");

endmodule : cpu_power_mode_control

// ---- sim/core_model.sv ----
// behavioural core: issues power control writes and instruction completion
// assumes the bench asks for one write with a one-cycle go pulse
`timescale 1ns/1ps

module core_model
(
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] data,
   input  wire logic       slow,
   output logic            wr,
   output logic [7:0]      wdata,
   output logic            done
);
   int gap;

   // quiet outputs before the first falling edge
   initial
   begin
      wr = 1'b0;
      wdata = 8'h00;
      done = 1'b0;
      gap = 0;
   end

   // write cycle, then completion one or three cycles later; released
   // data toggles so a stale byte never looks like a valid one
   always @(negedge clk)
   begin
      wr <= go;
      wdata <= go ? data : ~wdata;
      if (go)
         gap <= slow ? 3 : 1;
      else if (gap != 0)
         gap <= gap - 1;
      done <= (gap == 1);
   end
endmodule : core_model

// ---- sim/cpu_power_mode_control_tb.sv ----
// self-checking bench of the core power-mode controller
// assumes the core model makes the writes; reset and pins come from here
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"

module cpu_power_mode_control_tb;
   localparam int CKDET_CYC = 20;
   logic        REF_CLK = 1'b0, RST = 1'b1, go = 1'b0, slow = 1'b0;
   logic [7:0]  data = 8'h00;
   logic        IRQ_PENDING = 1'b0, INT_RESET_REQ = 1'b0;
   logic        WDOG_ENABLE = 1'b0, WDOG_EXPIRED = 1'b0;
   logic        CKDET_ENABLE = 1'b0, EXT_RESET_N = 1'b1;
   logic        SUSPEND_REQ = 1'b0, USB_NONIDLE = 1'b0, VBUS = 1'b0;
   logic        VBUS_WAKE_POLARITY = 1'b1;
   wire         PWRCTL_WR, INSTR_DONE;
   wire  [7:0]  PWRCTL_WDATA;
   logic        CPU_HALT, CPU_CLK_EN, PERIPH_CLK_EN, IRQ_ACTIVE, INT_OSC_EN;
   logic        RESET_OUT, IRQ_WAKE;
   logic [1:0]  POWER_MODE;
   logic [15:0] RESET_VECTOR;
   logic [7:0]  PWRCTL_RDATA;
   int          err_total = 0, n_checks = 0;

   // 100 MHz reference
   always #5 REF_CLK = ~REF_CLK;

   core_model i_core (.clk(REF_CLK), .go(go), .data(data), .slow(slow),
      .wr(PWRCTL_WR), .wdata(PWRCTL_WDATA), .done(INSTR_DONE));

   // short detector timeout keeps the stop runs brief
   cpu_power_mode_control #(.CKDET_TIMEOUT_CYC(CKDET_CYC)) i_dut (
      .REF_CLK(REF_CLK), .RST(RST), .PWRCTL_WR(PWRCTL_WR),
      .PWRCTL_WDATA(PWRCTL_WDATA), .INSTR_DONE(INSTR_DONE),
      .IRQ_PENDING(IRQ_PENDING), .INT_RESET_REQ(INT_RESET_REQ),
      .WDOG_ENABLE(WDOG_ENABLE), .WDOG_EXPIRED(WDOG_EXPIRED),
      .CKDET_ENABLE(CKDET_ENABLE), .EXT_RESET_N(EXT_RESET_N),
      .SUSPEND_REQ(SUSPEND_REQ), .USB_NONIDLE(USB_NONIDLE), .VBUS(VBUS),
      .VBUS_WAKE_POLARITY(VBUS_WAKE_POLARITY), .CPU_HALT(CPU_HALT),
      .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
      .IRQ_ACTIVE(IRQ_ACTIVE), .INT_OSC_EN(INT_OSC_EN),
      .RESET_OUT(RESET_OUT), .IRQ_WAKE(IRQ_WAKE), .POWER_MODE(POWER_MODE),
      .RESET_VECTOR(RESET_VECTOR), .PWRCTL_RDATA(PWRCTL_RDATA));

   // common tally of every comparison, with a report of each failing one
   task automatic tally(input logic ok, input logic [15:0] got, exp);
      n_checks++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : tally

   task automatic chk_bit(input logic got, exp);
      tally(got === exp, 16'(got), 16'(exp));
   endtask : chk_bit

   task automatic chk_mode(input logic [1:0] got, exp);
      tally(got === exp, 16'(got), 16'(exp));
   endtask : chk_mode

   task automatic chk_word(input logic [15:0] got, exp);
      tally(got === exp, got, exp);
   endtask : chk_word

   task automatic end_sim;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   // sample just after a rising edge, once its updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask : step

   // one write, then wait for completion; mode must not move before it
   task automatic put(input logic [7:0] d, input logic s);
      logic ok;
      ok = 1'b0;
      @(negedge REF_CLK);
      go <= 1'b1;
      data <= d;
      slow <= s;
      @(negedge REF_CLK);
      go <= 1'b0;
      for (int i = 0; i < 8 && !ok; i++)
      begin
         step(1);
         if (INSTR_DONE === 1'b1)
            ok = 1'b1;
         else
            chk_mode(POWER_MODE, `MODE_RUN);
      end
      chk_bit(ok, 1'b1);
      if (!ok)
         end_sim();
   endtask : put

   // count reset cycles seen in a window of w cycles
   task automatic count_rst(input int w, output int n);
      n = 0;
      repeat (w)
      begin
         step(1);
         if (RESET_OUT === 1'b1)
         begin
            n++;
            chk_mode(POWER_MODE, `MODE_RESET);
            chk_word(RESET_VECTOR, `RESET_VECTOR);
         end
      end
   endtask : count_rst

   task automatic sc_idle;
      put(8'hA5, 1'b1);
      chk_mode(POWER_MODE, `MODE_IDLE);
      chk_bit(CPU_CLK_EN, 1'b0);
      chk_bit(PERIPH_CLK_EN, 1'b1);
      chk_bit(IRQ_ACTIVE, 1'b1);
      chk_bit(INT_OSC_EN, 1'b1);
      chk_word(16'(PWRCTL_RDATA), 16'h00A4);
      // watchdog disabled: its timeout must not end idle
      @(negedge REF_CLK);
      WDOG_EXPIRED <= 1'b1;
      WDOG_EXPIRED <= #10 1'b0;
      step(4);
      chk_mode(POWER_MODE, `MODE_IDLE);
      chk_bit(RESET_OUT, 1'b0);
      @(negedge REF_CLK);
      IRQ_PENDING <= 1'b1;
      step(1);
      chk_bit(IRQ_WAKE, 1'b1);
      chk_mode(POWER_MODE, `MODE_RUN);
      chk_bit(CPU_CLK_EN, 1'b1);
      @(negedge REF_CLK);
      IRQ_PENDING <= 1'b0;
      step(1);
      chk_bit(IRQ_WAKE, 1'b0);
      chk_word(16'(PWRCTL_RDATA), 16'h00A4);
   endtask : sc_idle

   task automatic sc_wdt;
      int n;
      @(negedge REF_CLK);
      WDOG_ENABLE <= 1'b1;
      put(8'h01, 1'b0);
      chk_mode(POWER_MODE, `MODE_IDLE);
      @(negedge REF_CLK);
      WDOG_EXPIRED <= 1'b1;
      WDOG_EXPIRED <= #10 1'b0;
      count_rst(12, n);
      chk_word(16'(n), 16'h0004);
      chk_mode(POWER_MODE, `MODE_RUN);
      @(negedge REF_CLK);
      WDOG_ENABLE <= 1'b0;
   endtask : sc_wdt

   // stop ignores interrupts and leaves only through reset
   task automatic sc_stop;
      int n;
      // analog parts are the core's to shut before this write
      put(8'h02, 1'b0);
      chk_mode(POWER_MODE, `MODE_STOP);
      chk_bit(CPU_HALT, 1'b1);
      chk_bit(PERIPH_CLK_EN, 1'b0);
      chk_bit(IRQ_ACTIVE, 1'b0);
      chk_bit(INT_OSC_EN, 1'b0);
      @(negedge REF_CLK);
      IRQ_PENDING <= 1'b1;
      count_rst(30, n);
      chk_word(16'(n), 16'h0000);
      chk_mode(POWER_MODE, `MODE_STOP);
      chk_bit(IRQ_WAKE, 1'b0);
      @(negedge REF_CLK);
      IRQ_PENDING <= 1'b0;
      INT_RESET_REQ <= 1'b1;
      INT_RESET_REQ <= #10 1'b0;
      count_rst(12, n);
      chk_word(16'(n), 16'h0004);
      chk_mode(POWER_MODE, `MODE_RUN);
      chk_bit(INT_OSC_EN, 1'b1);
   endtask : sc_stop

   // both select bits, then the external pin ends stop
   task automatic sc_both;
      int n;
      put(8'h03, 1'b0);
      chk_mode(POWER_MODE, `MODE_STOP);
      @(negedge REF_CLK);
      EXT_RESET_N <= 1'b0;
      EXT_RESET_N <= #60 1'b1;
      count_rst(25, n);
      chk_bit(n >= 4, 1'b1);
      chk_mode(POWER_MODE, `MODE_RUN);
   endtask : sc_both

   task automatic sc_ckdet;
      int n;
      @(negedge REF_CLK);
      CKDET_ENABLE <= 1'b1;
      put(8'h02, 1'b0);
      count_rst(CKDET_CYC - 5, n);
      chk_word(16'(n), 16'h0000);
      chk_mode(POWER_MODE, `MODE_STOP);
      count_rst(20, n);
      chk_word(16'(n), 16'h0004);
      chk_mode(POWER_MODE, `MODE_RUN);
      @(negedge REF_CLK);
      CKDET_ENABLE <= 1'b0;
   endtask : sc_ckdet

   // suspend with no wake condition true, then wait for a given wake
   task automatic suspend_osc;
      @(negedge REF_CLK);
      SUSPEND_REQ <= 1'b1;
      SUSPEND_REQ <= #10 1'b0;
      step(8);
      chk_bit(INT_OSC_EN, 1'b0);
   endtask : suspend_osc

   task automatic wait_osc;
      for (int i = 0; i < 10 && INT_OSC_EN !== 1'b1; i++)
         step(1);
      chk_bit(INT_OSC_EN, 1'b1);
      if (INT_OSC_EN !== 1'b1)
         end_sim();
      step(6);
   endtask : wait_osc

   task automatic sc_suspend;
      suspend_osc();
      @(negedge REF_CLK);
      USB_NONIDLE <= 1'b1;
      wait_osc();
      @(negedge REF_CLK);
      USB_NONIDLE <= 1'b0;
      step(6);
      suspend_osc();
      @(negedge REF_CLK);
      VBUS <= 1'b1;
      wait_osc();
      @(negedge REF_CLK);
      VBUS_WAKE_POLARITY <= 1'b0;
      step(6);
      suspend_osc();
      @(negedge REF_CLK);
      VBUS <= 1'b0;
      wait_osc();
   endtask : sc_suspend

   // reset for four cycles, then every scenario in turn
   initial
   begin
      repeat (4) @(negedge REF_CLK);
      RST <= 1'b0;
      step(2);
      chk_mode(POWER_MODE, `MODE_RUN);
      chk_bit(CPU_CLK_EN, 1'b1);
      chk_word(16'(PWRCTL_RDATA), 16'h0000);
      sc_idle();
      sc_wdt();
      sc_stop();
      sc_both();
      sc_ckdet();
      sc_suspend();
      end_sim();
   end
endmodule : cpu_power_mode_control_tb
